// >>> shu_map.vh
// Purpose: Constants for the shift unit: instruction fields and opcodes
// Assumes: 32-bit R-type instruction words
// Notes: Included by the shift unit design file only; the barrel shifter does not use it
`ifndef SHU_MAP_VH
`define SHU_MAP_VH

// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define SHU_OP_HI 5
`define SHU_OP_LO 0
`define SHU_OPX_HI 16
`define SHU_OPX_LO 11
`define SHU_IMM_HI 10
`define SHU_IMM_LO 6
`define SHU_A_HI 31
`define SHU_A_LO 27
`define SHU_B_HI 26
`define SHU_B_LO 22
`define SHU_C_HI 21
`define SHU_C_LO 17

// ----------------------------------------
// Opcode values
// ----------------------------------------
`define SHU_OP_RTYPE 6'h3a
`define SHU_OPX_SLLI 6'h12
`define SHU_OPX_SRA 6'h3b
`define SHU_OPX_SRAI 6'h3a
`define SHU_OPX_SRL 6'h1b

// ----------------------------------------
// Operation selects
// ----------------------------------------
`define SHU_SEL_SLLI 2'h0
`define SHU_SEL_SRA 2'h1
`define SHU_SEL_SRAI 2'h2
`define SHU_SEL_SRL 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SHU_RESULT_RST 32'h0000_0000
`define SHU_DEST_RST 5'h00

`endif

// >>> shu_barrel.v
// Purpose: Combinational 32-bit barrel shifter, left or right, zero or sign fill
// Assumes: Count is five bits
// Notes: Used by shu_shift_unit
`timescale 1ns/10ps
module shu_barrel
(
   // Operands
   input wire [31:0] data_in,
   input wire [4:0] count,
   // Control
   input wire shift_left,
   input wire arith,
   // Result
   output reg [31:0] data_out
);

   reg signed [31:0] sdata;

   always @*
   begin
      sdata = data_in;
      if (shift_left)
      begin
         data_out = data_in << count;
      end
      else if (arith)
      begin
         data_out = sdata >>> count;
      end
      else
      begin
         data_out = data_in >> count;
      end
   end

endmodule

// >>> shu_shift_unit.v
// Purpose: Shift unit for immediate-left, register/immediate arithmetic right
//          and register logical right instructions
// Assumes: Decode stage presents instruction and register values with valid
// Notes: One cycle of latency; result and destination index are registered
//        Words that are not one of the four forms drop the valid and leave result and destination holding
//        Register forms ignore bits 10..6 of the word
`timescale 1ns/10ps
`include "shu_map.vh"
module shu_shift_unit
(
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Decode stage
   input wire instr_valid,
   input wire [31:0] instr_word,
   input wire [31:0] first_source_operand,
   input wire [31:0] second_source_operand,
   // Write-back
   output reg result_valid_q,
   output reg [31:0] result_q,
   output reg [4:0] destination_operand_q,
   output reg exception_q
);

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // One shift form: R-type opcode, matching extended opcode and, for the
   // immediate forms, a zero second register field
   function shu_match;
      input [31:0] word;
      input [5:0] opx_code;
      input imm_form;
      begin
         shu_match = (word[`SHU_OP_HI:`SHU_OP_LO] == `SHU_OP_RTYPE)
            && (word[`SHU_OPX_HI:`SHU_OPX_LO] == opx_code)
            && (!imm_form || (word[`SHU_B_HI:`SHU_B_LO] == 5'h00));
      end
   endfunction

   function shu_sel_left;
      input [1:0] sel_in;
      begin
         shu_sel_left = (sel_in == `SHU_SEL_SLLI);
      end
   endfunction

   function shu_sel_arith;
      input [1:0] sel_in;
      begin
         shu_sel_arith = (sel_in == `SHU_SEL_SRA) || (sel_in == `SHU_SEL_SRAI);
      end
   endfunction

   function shu_sel_reg;
      input [1:0] sel_in;
      begin
         shu_sel_reg = (sel_in == `SHU_SEL_SRA) || (sel_in == `SHU_SEL_SRL);
      end
   endfunction

   // Register forms take the low five bits of the second source register
   function [4:0] shu_count_sel;
      input reg_form_in;
      input [4:0] reg_low;
      input [4:0] imm_value;
      begin
         if (reg_form_in)
         begin
            shu_count_sel = reg_low;
         end
         else
         begin
            shu_count_sel = imm_value;
         end
      end
   endfunction

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire [4:0] shift_count_immediate;
   wire [4:0] c_index;
   wire match_left_imm;
   wire match_arith_reg;
   wire match_arith_imm;
   wire match_logic_reg;
   reg hit;
   reg [1:0] sel;

   assign shift_count_immediate = instr_word[`SHU_IMM_HI:`SHU_IMM_LO];
   assign c_index = instr_word[`SHU_C_HI:`SHU_C_LO];
   // Extended opcodes differ, so at most one match line is high
   assign match_left_imm = shu_match(instr_word, `SHU_OPX_SLLI, 1'b1);
   assign match_arith_reg = shu_match(instr_word, `SHU_OPX_SRA, 1'b0);
   assign match_arith_imm = shu_match(instr_word, `SHU_OPX_SRAI, 1'b1);
   assign match_logic_reg = shu_match(instr_word, `SHU_OPX_SRL, 1'b0);

   // Any other word leaves hit low, drops the valid and leaves result and destination holding
   always @*
   begin
      hit = 1'b0;
      sel = `SHU_SEL_SLLI;
      case ({match_left_imm, match_arith_reg, match_arith_imm, match_logic_reg})
         4'h8:
         begin
            hit = 1'b1;
            sel = `SHU_SEL_SLLI;
         end
         4'h4:
         begin
            hit = 1'b1;
            sel = `SHU_SEL_SRA;
         end
         4'h2:
         begin
            hit = 1'b1;
            sel = `SHU_SEL_SRAI;
         end
         4'h1:
         begin
            hit = 1'b1;
            sel = `SHU_SEL_SRL;
         end
         default:
         begin
            hit = 1'b0;
            sel = `SHU_SEL_SLLI;
         end
      endcase
   end

   // ----------------------------------------
   // Shift datapath
   // ----------------------------------------
   wire reg_form;
   wire left_shift;
   wire arith_fill;
   wire [4:0] count;
   wire [31:0] shifted;

   assign reg_form = shu_sel_reg(sel);
   assign left_shift = shu_sel_left(sel);
   // Sign fill for both arithmetic forms; logical right fills zeros
   assign arith_fill = shu_sel_arith(sel);
   assign count = shu_count_sel(reg_form, second_source_operand[4:0], shift_count_immediate);

   shu_barrel u_barrel
   (
      .data_in(first_source_operand),
      .count(count),
      .shift_left(left_shift),
      .arith(arith_fill),
      .data_out(shifted)
   );

   // ----------------------------------------
   // Write-back registers
   // ----------------------------------------
   wire accept;

   assign accept = instr_valid & hit;

   // Valid pulse: one cycle per accepted shift
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         result_valid_q <= 1'b0;
      end
      else
      begin
         result_valid_q <= accept;
      end
   end

   // Result and destination hold until the next accepted shift
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         result_q <= `SHU_RESULT_RST;
      end
      else if (accept)
      begin
         result_q <= shifted;
      end
   end

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         destination_operand_q <= `SHU_DEST_RST;
      end
      else if (accept)
      begin
         destination_operand_q <= c_index;
      end
   end

   // No shift form can fault, so the flag stays low
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         exception_q <= 1'b0;
      end
      else
      begin
         exception_q <= 1'b0;
      end
   end

endmodule

// >>> shu_props.sv
// Purpose: Port checks of the shift unit
// Assumes: One cycle latency
// Notes: Bound at the foot
`timescale 1ns/10ps
module shu_props
(
   input wire sys_clk,
   input wire rst,
   input wire instr_valid,
   input wire [31:0] instr_word,
   input wire [31:0] first_source_operand,
   input wire [31:0] second_source_operand,
   input wire result_valid_q,
   input wire [31:0] result_q,
   input wire [4:0] destination_operand_q,
   input wire exception_q
);
   wire [31:0] w = instr_word;
   wire [31:0] a = first_source_operand;
   wire [5:0] x = w[16:11];
   wire i = x == 6'h12 || x == 6'h3a;
   wire [4:0] n = i ? w[10:6] : second_source_operand[4:0];
   wire go = instr_valid && w[5:0] == 6'h3a && (i ? !w[26:22] : x[4:0] == 5'h1b);
   wire [4:0] c = w[21:17];
   wire signed [31:0] s = $signed(a) >>> n;
   wire [31:0] e = x == 6'h12 ? a << n : x == 6'h1b ? a >> n : s;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   take_word_a: assert property (go |=> result_valid_q) else $error("lost");
   skip_word_a: assert property (!go |=> !result_valid_q && $stable(result_q))
      else $error("taken");
   left_imm_a: assert property (go && x == 6'h12 |=> result_q == $past(e))
      else $error("sll");
   arith_reg_a: assert property (go && x == 6'h3b |=> result_q == $past(e))
      else $error("sra");
   arith_imm_a: assert property (go && x == 6'h3a |=> result_q == $past(e))
      else $error("srai");
   logic_reg_a: assert property (go && x == 6'h1b |=> result_q == $past(e))
      else $error("srl");
   dest_index_a: assert property (go |=> destination_operand_q == $past(c))
      else $error("dest");
   no_exc_a: assert property (!exception_q) else $error("exc");
   reset_clear_a: assert property (disable iff (1'b0) rst |=> !result_valid_q
      && result_q == 32'h0000_0000 && destination_operand_q == 5'h00 && !exception_q)
      else $error("reset");
endmodule
bind shu_shift_unit shu_props u_props
(
   .sys_clk(sys_clk),
   .rst(rst),
   .instr_valid(instr_valid),
   .instr_word(instr_word),
   .first_source_operand(first_source_operand),
   .second_source_operand(second_source_operand),
   .result_valid_q(result_valid_q),
   .result_q(result_q),
   .destination_operand_q(destination_operand_q),
   .exception_q(exception_q)
);

// >>> shu_decoder.sv
// Purpose: Decode stage and register file stand-in
// Assumes: Bench supplies word and operands
// Notes: Idle lines carry a changing pattern
`timescale 1ns/10ps
module shu_decoder
(
   input wire sys_clk,
   input wire send,
   input wire [95:0] req,
   output wire instr_valid,
   output wire [31:0] instr_word,
   output wire [31:0] first_source_operand,
   output wire [31:0] second_source_operand
);
   reg [95:0] junk = 96'h0;
   always @(posedge sys_clk)
   begin
      junk <= ~junk;
   end
   assign instr_valid = send;
   assign {instr_word, first_source_operand, second_source_operand} = send ? req : junk;
endmodule

// >>> test_shift_unit.sv
// Purpose: Random self-check of the shift unit
// Assumes: One cycle latency
// Notes: Model queue runs two entries deep
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH %0t %h %h", $time, g, e); end end
module test_shift_unit;
   reg sys_clk = 0;
   reg rst = 1;
   reg send = 0;
   reg [95:0] req = 0;
   wire instr_valid, result_valid_q, exception_q;
   wire [31:0] instr_word, first_source_operand, second_source_operand, result_q;
   wire [4:0] destination_operand_q;
   integer failures = 0, checked = 0, seed = 32'h396a, k, s;
   reg [31:0] x, y, z, e;
   reg [37:0] q[$];
   reg [37:0] t;
   reg [4:0] n;
   reg [5:0] ops [0:3] = '{6'h12, 6'h3b, 6'h3a, 6'h1b};
   always #5 sys_clk = ~sys_clk;
   shu_decoder u_dec
   (
      .sys_clk(sys_clk),
      .send(send),
      .req(req),
      .instr_valid(instr_valid),
      .instr_word(instr_word),
      .first_source_operand(first_source_operand),
      .second_source_operand(second_source_operand)
   );
   shu_shift_unit u_dut
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .instr_valid(instr_valid),
      .instr_word(instr_word),
      .first_source_operand(first_source_operand),
      .second_source_operand(second_source_operand),
      .result_valid_q(result_valid_q),
      .result_q(result_q),
      .destination_operand_q(destination_operand_q),
      .exception_q(exception_q)
   );
   task final_report;
   begin
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   initial
   begin
      #20000;
      failures++;
      final_report;
   end
   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst <= 0;
      repeat (600)
      begin
         @(posedge sys_clk);
         if (q.size() > 1)
         begin
            t = q.pop_front();
            `CHK(result_valid_q, t[37])
            if (t[37])
               `CHK({destination_operand_q, result_q}, t[36:0])
            `CHK(exception_q, 1'h0)
         end
         k = $random(seed);
         x = $random(seed);
         y = $random(seed);
         z = $random(seed);
         x[5:0] = k[5:3] ? 6'h3a : 6'h3b;
         x[16:11] = ops[k[1:0]];
         if (k[10:8] == 3'h0)
            x[16:11] = 6'h00;
         if (!k[0] && k[2])
            x[26:22] = 5'h0;
         n = k[0] ? z[4:0] : x[10:6];
         s = $signed(y) >>> n;
         e = k[1:0] == 0 ? y << n : k[1:0] == 3 ? y >> n : s;
         send <= k[6] | k[7];
         req <= {x, y, z};
         q.push_back({(k[6] | k[7]) && k[5:3] && k[10:8] && (k[0] || !x[26:22]), x[21:17], e});
      end
      final_report;
   end
endmodule
